// ===== hdl/pvcos_conditioner.sv
// Local design decisions: the strobed register port and the address map.
`default_nettype none
module pvcos_conditioner #(
  parameter int         TICK_CYCLES  = pvcos_pkg::TICK_CYCLES_DEF,
  parameter bit         INPUT_ANALOG = 1'b1,
  parameter bit         TWO_OUTPUTS  = 1'b1,
  parameter logic [1:0] OUT_ONE_KIND = pvcos_pkg::KIND_CONTACT,
  parameter logic [1:0] OUT_TWO_KIND = pvcos_pkg::KIND_SSR
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [5:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output var  logic [15:0] regRdata,
  input  wire logic [15:0] pvRawIn,
  input  wire logic        sensorErrIn,
  input  wire logic        autoTuning,
  input  wire logic        rampActive,
  input  wire logic [9:0]  ctrlDemandOne,
  input  wire logic [9:0]  ctrlDemandTwo,
  output var  logic [15:0] pvExec,
  output var  logic        actionDirectOne,
  output var  logic        actionDirectTwo,
  output var  logic [13:0] outLevelOne,
  output var  logic [13:0] outLevelTwo,
  output var  logic        relayOne,
  output var  logic        relayTwo
);

  typedef struct packed {
    logic [15:0]            rawS1;
    logic [15:0]            rawS2;
    logic                   errS1;
    logic                   errS2;
    logic [19:0]            tickCnt;
    pvcos_pkg::pvcos_phase_e phase;
    logic                   standby;
    logic                   onOff;
    logic                   sqrtEn;
    logic                   linEn;
    logic [1:0]             actDirect;
    logic [15:0]            bias;
    logic [6:0]             filt;
    logic [10:0]            slope;
    logic [5:0]             lowCut;
    logic [1:0][9:0]        stbyVal;
    logic [1:0][9:0]        errVal;
    logic [1:0][6:0]        cyc;
    logic [1:0][9:0]        rate;
    logic [10:0][15:0]      bpIn;
    logic [10:0][15:0]      bpDisp;
    logic [15:0]            cond;
    logic [31:0]            filtAcc;
    logic [15:0]            pv;
    logic [1:0][13:0]       outLevel;
    logic [1:0][10:0]       cycCnt;
    logic [1:0]             relay;
    logic [15:0]            rdata;
  } pvcos_state_s;

  function automatic logic [6:0] cycDefault(input logic [1:0] kind);
    return (kind == pvcos_pkg::KIND_SSR) ? 7'(pvcos_pkg::CYC_DEF_SSR)
                                         : 7'(pvcos_pkg::CYC_DEF_CONTACT);
  endfunction : cycDefault

  localparam pvcos_state_s RESET_STATE = '{
    phase:     pvcos_pkg::ST_IDLE,
    actDirect: 2'h2,
    slope:     11'(pvcos_pkg::SLOPE_UNITY),
    lowCut:    6'(pvcos_pkg::LOWCUT_DEF),
    cyc:       {cycDefault(OUT_TWO_KIND), cycDefault(OUT_ONE_KIND)},
    default:   '0
  };

  // Output two registers vanish on the single-output variant
  function automatic int outSlot(input logic [5:0] addr);
    int off;
    off = int'(addr) - int'(pvcos_pkg::REG_OUT_BASE);
    if (off < 0 || off >= 2 * pvcos_pkg::OUT_STRIDE) return -1;
    if (off >= pvcos_pkg::OUT_STRIDE && !TWO_OUTPUTS) return -1;
    return off;
  endfunction : outSlot

  function automatic int bpSlot(input logic [5:0] addr, input logic [5:0] base);
    int off;
    off = int'(addr) - int'(base);
    if (off < 0 || off >= pvcos_pkg::BP_NUM) return -1;
    return off;
  endfunction : bpSlot

  function automatic logic [15:0] sat16(input int v);
    if (v > 32767) return 16'h7fff;
    if (v < -32768) return 16'h8000;
    return 16'(v);
  endfunction : sat16

  function automatic int isqrt(input int v);
    int r;
    int b;
    r = 0;
    for (int i = 13; i >= 0; i--) begin
      b = r + (1 << i);
      if (b * b <= v) r = b;
    end
    return r;
  endfunction : isqrt

  // Breakpoint inputs must rise; the first that falls or repeats cuts the table there
  function automatic int linearize(input int x, input logic [10:0][15:0] a,
                                   input logic [10:0][15:0] b);
    int n;
    int k;
    int a0;
    int a1;
    int b0;
    int b1;
    n = pvcos_pkg::BP_NUM;
    k = 0;
    for (int i = 0; i < pvcos_pkg::BP_NUM - 1; i++) begin
      if (n == pvcos_pkg::BP_NUM && $signed(a[i + 1]) <= $signed(a[i])) n = i + 1;
    end
    if (n < 2) return x;
    for (int i = 1; i < pvcos_pkg::BP_NUM - 1; i++) begin
      if (i <= n - 2 && x >= int'($signed(a[i]))) k = i;
    end
    a0 = int'($signed(a[k]));
    a1 = int'($signed(a[k + 1]));
    b0 = int'($signed(b[k]));
    b1 = int'($signed(b[k + 1]));
    return b0 + (x - a0) * (b1 - b0) / (a1 - a0);
  endfunction : linearize

  function automatic int fixedOut(input int v, input logic onOff);
    if (!onOff) return v;
    return (v >= pvcos_pkg::ONOFF_HALF) ? pvcos_pkg::PCT_MAX : 0;
  endfunction : fixedOut

  pvcos_state_s s_q;
  pvcos_state_s s_d;

  always_comb begin
    int v;
    int m;
    int os;
    int bi;
    int tgt;
    int cur;
    int nxt;
    int wv;
    logic [1:0][9:0] demand;
    v = 0;
    m = 0;
    os = -1;
    bi = -1;
    tgt = 0;
    cur = 0;
    nxt = 0;
    wv = int'($signed(regWdata));
    demand = {ctrlDemandTwo, ctrlDemandOne};
    s_d = s_q;
    // First stage only feeds the second; nothing else looks at it
    s_d.rawS1 = pvRawIn;
    s_d.rawS2 = s_q.rawS1;
    s_d.errS1 = sensorErrIn;
    s_d.errS2 = s_q.errS1;
    s_d.rdata = '0;

    if (regWrite) begin
      os = outSlot(regAddr);
      case (regAddr)
        pvcos_pkg::REG_CTRL: begin
          s_d.standby = regWdata[pvcos_pkg::CB_STANDBY];
          s_d.onOff = regWdata[pvcos_pkg::CB_ONOFF];
          s_d.sqrtEn = regWdata[pvcos_pkg::CB_SQRT] & INPUT_ANALOG;
          s_d.linEn = regWdata[pvcos_pkg::CB_LIN] & INPUT_ANALOG;
          if (!autoTuning) begin
            s_d.actDirect[0] = regWdata[pvcos_pkg::CB_ACT];
            if (TWO_OUTPUTS) s_d.actDirect[1] = regWdata[pvcos_pkg::CB_ACT + 1];
          end
        end
        pvcos_pkg::REG_BIAS: begin
          if (wv >= pvcos_pkg::BIAS_MIN && wv <= pvcos_pkg::BIAS_MAX) s_d.bias = regWdata;
        end
        pvcos_pkg::REG_FILT: begin
          if (int'(regWdata) <= pvcos_pkg::FILT_MAX) s_d.filt = regWdata[6:0];
        end
        pvcos_pkg::REG_SLOPE: begin
          if (INPUT_ANALOG && int'(regWdata) >= pvcos_pkg::SLOPE_MIN
              && int'(regWdata) <= pvcos_pkg::SLOPE_MAX) s_d.slope = regWdata[10:0];
        end
        pvcos_pkg::REG_LOWCUT: begin
          if (int'(regWdata) <= pvcos_pkg::LOWCUT_MAX) s_d.lowCut = regWdata[5:0];
        end
        default: begin
          if (os >= 0) begin
            case (os % pvcos_pkg::OUT_STRIDE)
              pvcos_pkg::OF_CONTROL_STANDBY: begin
                if (int'(regWdata) <= pvcos_pkg::PCT_MAX)
                  s_d.stbyVal[os / pvcos_pkg::OUT_STRIDE] = regWdata[9:0];
              end
              pvcos_pkg::OF_ERR: begin
                if (int'(regWdata) <= pvcos_pkg::PCT_MAX)
                  s_d.errVal[os / pvcos_pkg::OUT_STRIDE] = regWdata[9:0];
              end
              pvcos_pkg::OF_CYC: begin
                if (!autoTuning && !rampActive && int'(regWdata) >= pvcos_pkg::CYC_MIN
                    && int'(regWdata) <= pvcos_pkg::CYC_MAX)
                  s_d.cyc[os / pvcos_pkg::OUT_STRIDE] = regWdata[6:0];
              end
              default: begin
                if (int'(regWdata) <= pvcos_pkg::RATE_MAX)
                  s_d.rate[os / pvcos_pkg::OUT_STRIDE] = regWdata[9:0];
              end
            endcase
          end
          bi = bpSlot(regAddr, pvcos_pkg::REG_BP_IN);
          if (bi >= 0 && wv >= pvcos_pkg::BP_MIN && wv <= pvcos_pkg::BP_MAX)
            s_d.bpIn[bi] = regWdata;
          bi = bpSlot(regAddr, pvcos_pkg::REG_BP_DISP);
          if (bi >= 0 && wv >= pvcos_pkg::BP_MIN && wv <= pvcos_pkg::BP_MAX)
            s_d.bpDisp[bi] = regWdata;
        end
      endcase
    end

    if (regRead) begin
      os = outSlot(regAddr);
      case (regAddr)
        pvcos_pkg::REG_CTRL: begin
          s_d.rdata = 16'({s_q.actDirect, s_q.linEn, s_q.sqrtEn, s_q.onOff, s_q.standby});
        end
        pvcos_pkg::REG_BIAS: s_d.rdata = s_q.bias;
        pvcos_pkg::REG_FILT: s_d.rdata = 16'(s_q.filt);
        pvcos_pkg::REG_SLOPE: s_d.rdata = INPUT_ANALOG ? 16'(s_q.slope) : '0;
        pvcos_pkg::REG_LOWCUT: s_d.rdata = 16'(s_q.lowCut);
        pvcos_pkg::REG_PV: s_d.rdata = s_q.pv;
        pvcos_pkg::REG_STATUS: s_d.rdata = 16'({s_q.relay, rampActive, autoTuning, s_q.errS2});
        default: begin
          if (os >= 0) begin
            case (os % pvcos_pkg::OUT_STRIDE)
              pvcos_pkg::OF_CONTROL_STANDBY: s_d.rdata = 16'(s_q.stbyVal[os / pvcos_pkg::OUT_STRIDE]);
              pvcos_pkg::OF_ERR: s_d.rdata = 16'(s_q.errVal[os / pvcos_pkg::OUT_STRIDE]);
              pvcos_pkg::OF_CYC: s_d.rdata = 16'(s_q.cyc[os / pvcos_pkg::OUT_STRIDE]);
              default: s_d.rdata = 16'(s_q.rate[os / pvcos_pkg::OUT_STRIDE]);
            endcase
          end
          bi = bpSlot(regAddr, pvcos_pkg::REG_BP_IN);
          if (bi >= 0) s_d.rdata = s_q.bpIn[bi];
          bi = bpSlot(regAddr, pvcos_pkg::REG_BP_DISP);
          if (bi >= 0) s_d.rdata = s_q.bpDisp[bi];
        end
      endcase
    end

    // One sample per tick; the stages run on consecutive cycles
    case (s_q.phase)
      pvcos_pkg::ST_IDLE: begin
        if (int'(s_q.tickCnt) >= TICK_CYCLES - 1) begin
          s_d.tickCnt = '0;
          s_d.phase = pvcos_pkg::ST_CALC;
        end else begin
          s_d.tickCnt = s_q.tickCnt + 20'h00001;
        end
      end
      pvcos_pkg::ST_CALC: begin
        v = int'($signed(s_q.rawS2));
        if (s_q.sqrtEn) begin
          if (v <= int'(s_q.lowCut) * pvcos_pkg::LOWCUT_SCALE) v = 0;
          else begin
            if (v > pvcos_pkg::FULL_SCALE) v = pvcos_pkg::FULL_SCALE;
            v = isqrt(v * pvcos_pkg::FULL_SCALE);
          end
        end
        if (s_q.linEn && !(s_q.sqrtEn && v == 0)) v = linearize(v, s_q.bpIn, s_q.bpDisp);
        m = INPUT_ANALOG ? int'(s_q.slope) : pvcos_pkg::SLOPE_UNITY;
        s_d.cond = sat16(v * m / pvcos_pkg::SLOPE_UNITY + int'($signed(s_q.bias)));
        s_d.phase = pvcos_pkg::ST_FILT;
      end
      pvcos_pkg::ST_FILT: begin
        cur = int'($signed(s_q.filtAcc));
        nxt = int'($signed(s_q.cond)) <<< pvcos_pkg::FILT_FRAC;
        // Fractional bits stop small steps from stalling under long constants
        if (s_q.filt != '0)
          nxt = cur + (nxt - cur) / (int'(s_q.filt) * pvcos_pkg::TICKS_PER_S);
        s_d.filtAcc = 32'(nxt);
        s_d.pv = sat16(nxt >>> pvcos_pkg::FILT_FRAC);
        s_d.phase = pvcos_pkg::ST_OUTS;
      end
      pvcos_pkg::ST_OUTS: begin
        for (int i = 0; i < 2; i++) begin
          if (s_q.standby) tgt = fixedOut(int'(s_q.stbyVal[i]), s_q.onOff);
          else if (s_q.errS2) tgt = fixedOut(int'(s_q.errVal[i]), s_q.onOff);
          else if (int'(demand[i]) > pvcos_pkg::PCT_MAX) tgt = pvcos_pkg::PCT_MAX;
          else tgt = int'(demand[i]);
          tgt = tgt * pvcos_pkg::OUT_SCALE;
          cur = int'(s_q.outLevel[i]);
          if (s_q.rate[i] != '0) begin
            if (tgt > cur + int'(s_q.rate[i])) tgt = cur + int'(s_q.rate[i]);
            else if (tgt < cur - int'(s_q.rate[i])) tgt = cur - int'(s_q.rate[i]);
          end
          nxt = int'(s_q.cycCnt[i]) + 1;
          if (nxt >= int'(s_q.cyc[i]) * pvcos_pkg::TICKS_PER_S) nxt = 0;
          s_d.outLevel[i] = 14'(tgt);
          s_d.cycCnt[i] = 11'(nxt);
          s_d.relay[i] = (nxt * pvcos_pkg::FULL_SCALE
                          < tgt * int'(s_q.cyc[i]) * pvcos_pkg::TICKS_PER_S);
        end
        if (OUT_ONE_KIND == pvcos_pkg::KIND_ANALOG) s_d.relay[0] = 1'b0;
        if (OUT_TWO_KIND == pvcos_pkg::KIND_ANALOG) s_d.relay[1] = 1'b0;
        if (!TWO_OUTPUTS) begin
          s_d.outLevel[1] = '0;
          s_d.cycCnt[1] = '0;
          s_d.relay[1] = 1'b0;
        end
        s_d.phase = pvcos_pkg::ST_IDLE;
      end
      default: s_d.phase = pvcos_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) s_q <= RESET_STATE;
    else s_q <= s_d;
  end

  assign regRdata        = s_q.rdata;
  assign pvExec          = s_q.pv;
  assign actionDirectOne = s_q.actDirect[0];
  assign actionDirectTwo = s_q.actDirect[1];
  assign outLevelOne     = s_q.outLevel[0];
  assign outLevelTwo     = s_q.outLevel[1];
  assign relayOne        = s_q.relay[0];
  assign relayTwo        = s_q.relay[1];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seqOutStep;
    s_q.phase == pvcos_pkg::ST_OUTS && s_q.rate[0] == '0;
  endsequence

  sequence seqFiltOff;
    s_q.phase == pvcos_pkg::ST_FILT && s_q.filt == '0;
  endsequence

  a_bias_range: assert property (
    $signed(s_q.bias) >= 16'sd0 - 16'sd10000 && $signed(s_q.bias) <= 16'sd10000)
    else $error("bias left its range");

  a_filter_off: assert property (
    seqFiltOff |=> s_q.pv == $past(s_q.cond))
    else $error("disabled filter did not pass value through");

  a_slope_hidden: assert property (
    !INPUT_ANALOG |-> s_q.slope == 11'(pvcos_pkg::SLOPE_UNITY))
    else $error("slope changed on a non-analog input");

  a_lowcut_zero: assert property (
    (s_q.phase == pvcos_pkg::ST_CALC && s_q.sqrtEn
     && $signed(s_q.rawS2) <= $signed({10'h000, s_q.lowCut}) * 16'sd10)
    |=> s_q.cond == $past(s_q.bias))
    else $error("low cut did not force zero");

  a_act_locked: assert property (
    (regWrite && regAddr == pvcos_pkg::REG_CTRL && autoTuning) |=> $stable(s_q.actDirect))
    else $error("action changed during auto tuning");

  a_control_standby_hold: assert property (
    (seqOutStep and s_q.standby && !s_q.onOff)
    |=> s_q.outLevel[0] == 14'($past(s_q.stbyVal[0])) * 14'h000a)
    else $error("standby output not held");

  a_onoff_full: assert property (
    (seqOutStep and s_q.standby && s_q.onOff && s_q.stbyVal[0] >= 10'h1f4)
    |=> s_q.outLevel[0] == 14'h2710)
    else $error("on-off standby did not give full output");

  a_err_out: assert property (
    (seqOutStep and !s_q.standby && s_q.errS2 && !s_q.onOff)
    |=> s_q.outLevel[0] == 14'($past(s_q.errVal[0])) * 14'h000a)
    else $error("error output not applied");

  a_cyc_locked: assert property (
    (regWrite && regAddr == pvcos_pkg::REG_OUT_BASE + 6'h02 && (autoTuning || rampActive))
    |=> $stable(s_q.cyc[0]))
    else $error("cycle time changed while locked");

  a_rate_bound: assert property (
    (s_q.phase == pvcos_pkg::ST_OUTS && s_q.rate[0] != '0)
    |=> (s_q.outLevel[0] >= $past(s_q.outLevel[0])
         ? s_q.outLevel[0] - $past(s_q.outLevel[0])
         : $past(s_q.outLevel[0]) - s_q.outLevel[0]) <= 14'($past(s_q.rate[0])))
    else $error("output moved faster than the rate limit");

  a_relay_analog: assert property (
    (OUT_ONE_KIND == pvcos_pkg::KIND_ANALOG) |-> !s_q.relay[0])
    else $error("analog output drove a relay");

endmodule : pvcos_conditioner
`default_nettype wire

// ===== common/pvcos_pkg.sv
// What this block does
// - Add signed bias, -10000 to 10000, default zero
// - First-order lag filter, off or 1-100 s
// - Executed PV equals slope times input plus bias
// - Slope only for voltage or current inputs
// - Slope applies after square root and linearizer
// - Square root only when its enable is on
// - Low cut active only with square root
// - Input at or below low cut gives zero
// - Per-output reverse or direct action, defaults differ
// - Action changes refused during auto tuning
// - Standby holds each output at standby value
// - On-off mode maps fixed outputs to 0/100%
// - Error drives each output to error value
// - Standby output wins over error output
// - Relay and SSR outputs time-proportioned, 1-120 s
// - Cycle changes refused during tuning or ramp
// - Output two settings exist on two-output variant
// - Per-second output rate limit, off or 0.1-100%/s
// - Linearizer only for analog inputs, enable bit
// - Eleven breakpoints, linear interpolation between them
// - Extrapolate with first and last segment slopes
`default_nettype none
package pvcos_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_BIAS     = 6'h01;
  localparam logic [5:0] REG_FILT     = 6'h02;
  localparam logic [5:0] REG_SLOPE    = 6'h03;
  localparam logic [5:0] REG_LOWCUT   = 6'h04;
  localparam logic [5:0] REG_OUT_BASE = 6'h05;
  localparam logic [5:0] REG_PV       = 6'h0d;
  localparam logic [5:0] REG_STATUS   = 6'h0e;
  localparam logic [5:0] REG_BP_IN    = 6'h10;
  localparam logic [5:0] REG_BP_DISP  = 6'h20;
  localparam int OUT_STRIDE = 4;
  localparam int OF_CONTROL_STANDBY = 0;
  localparam int OF_ERR  = 1;
  localparam int OF_CYC  = 2;
  localparam int OF_RATE = 3;
  localparam int CB_STANDBY = 0;
  localparam int CB_ONOFF   = 1;
  localparam int CB_SQRT    = 2;
  localparam int CB_LIN     = 3;
  localparam int CB_ACT     = 4;
  localparam int BIAS_MIN = -10000;
  localparam int BIAS_MAX = 10000;
  localparam int FILT_MAX = 100;
  localparam int SLOPE_MIN = 500;
  localparam int SLOPE_MAX = 1500;
  localparam int SLOPE_UNITY = 1000;
  localparam int LOWCUT_MAX = 50;
  localparam int LOWCUT_DEF = 10;
  localparam int LOWCUT_SCALE = 10;
  localparam int PCT_MAX = 1000;
  localparam int ONOFF_HALF = 500;
  localparam int OUT_SCALE = 10;
  localparam int FULL_SCALE = 10000;
  localparam int CYC_MIN = 1;
  localparam int CYC_MAX = 120;
  localparam int CYC_DEF_CONTACT = 30;
  localparam int CYC_DEF_SSR = 3;
  localparam int RATE_MAX = 1000;
  localparam int BP_NUM = 11;
  localparam int BP_MIN = -500;
  localparam int BP_MAX = 10500;
  localparam int FILT_FRAC = 8;
  localparam int TICKS_PER_S = 10;
  localparam int CLK_FREQ_HZ = 10000000;
  localparam int SAMPLE_PERIOD_MS = 100;
  localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / 1000 * SAMPLE_PERIOD_MS;
  localparam logic [1:0] KIND_CONTACT = 2'h0;
  localparam logic [1:0] KIND_SSR     = 2'h1;
  localparam logic [1:0] KIND_ANALOG  = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_FILT = 2'b11,
    ST_OUTS = 2'b10
  } pvcos_phase_e;
endpackage : pvcos_pkg
`default_nettype wire

// ===== test/pvcos_plant_model.sv
`default_nettype none
module pvcos_plant_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] pvSet,
  input  wire logic        errSet,
  input  wire logic        relayOne,
  output var  logic [15:0] pvRawIn,
  output var  logic        sensorErrIn,
  output var  logic [15:0] onCountOne
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pvRawIn = 16'h0000;
    sensorErrIn = 1'b0;
    onCountOne = 16'h0000;
  end
  // Sensor steps right after the edge; the actuator tally is only sampled at edges
  always @(posedge sys_clk) begin
    pvRawIn <= pvSet;
    sensorErrIn <= errSet;
    if (relayOne === 1'b1) begin
      onCountOne <= onCountOne + 16'h0001;
    end
  end
endmodule : pvcos_plant_model
`default_nettype wire

// ===== test/pvcos_conditioner_tb_top.sv
`default_nettype none
module pvcos_conditioner_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 20;
  localparam int PER  = 23;
  logic sys_clk, rst, regWrite, regRead, autoTuning, rampActive, errSet;
  logic [5:0]  regAddr;
  logic [15:0] regWdata, regRdata, pvRawIn, pvExec, pvSet, onCountOne;
  logic [9:0]  ctrlDemandOne, ctrlDemandTwo;
  logic [13:0] outLevelOne, outLevelTwo;
  logic        sensorErrIn, actionDirectOne, actionDirectTwo, relayOne, relayTwo;
  int          nFail, checks, cycles;
  pvcos_conditioner #(.TICK_CYCLES(TICK)) dut (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pvRawIn(pvRawIn), .sensorErrIn(sensorErrIn),
    .autoTuning(autoTuning), .rampActive(rampActive), .ctrlDemandOne(ctrlDemandOne),
    .ctrlDemandTwo(ctrlDemandTwo), .pvExec(pvExec), .actionDirectOne(actionDirectOne),
    .actionDirectTwo(actionDirectTwo), .outLevelOne(outLevelOne),
    .outLevelTwo(outLevelTwo), .relayOne(relayOne), .relayTwo(relayTwo));
  pvcos_plant_model plant (.sys_clk(sys_clk), .pvSet(pvSet), .errSet(errSet),
    .relayOne(relayOne), .pvRawIn(pvRawIn), .sensorErrIn(sensorErrIn),
    .onCountOne(onCountOne));
  always #50 sys_clk = ~sys_clk;
  task automatic wrapUp();
    $display("checks %0d errors %0d", checks, nFail);
    if (nFail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrapUp
  // Ceiling well above the roughly 1600 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nFail++;
      wrapUp();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic rdChk(input string what, input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask : rdChk
  // Three sample periods cover the input synchroniser and the three stages
  task automatic settle();
    repeat (3 * PER) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic waitMove(input bit outSide);
    logic [15:0] old;
    int i;
    old = outSide ? {2'h0, outLevelOne} : pvExec;
    for (i = 0; i < 3 * PER && old === (outSide ? {2'h0, outLevelOne} : pvExec); i++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : waitMove
  task automatic tReset();
    chk("dirTwo", {15'h0, actionDirectTwo}, 16'h0001);
    chk("dirOne", {15'h0, actionDirectOne}, 16'h0000);
    chk("relayTwoRst", {15'h0, relayTwo}, 16'h0000);
    rdChk("ctrl", pvcos_pkg::REG_CTRL, 16'h0020);
    rdChk("bias", pvcos_pkg::REG_BIAS, 16'h0000);
    rdChk("filt", pvcos_pkg::REG_FILT, 16'h0000);
    rdChk("slope", pvcos_pkg::REG_SLOPE, 16'h03e8);
    rdChk("lowcut", pvcos_pkg::REG_LOWCUT, 16'h000a);
    rdChk("cycOne", 6'h07, 16'h001e);
    rdChk("cycTwo", 6'h0b, 16'h0003);
    rdChk("unmapped", 6'h0f, 16'h0000);
  endtask : tReset
  task automatic tFilter();
    wr(pvcos_pkg::REG_FILT, 16'h0001);
    settle();
    pvSet <= 16'h2710;
    waitMove(1'b0);
    chk("lagFirst", pvExec, 16'h03e8);
    waitMove(1'b0);
    chk("lagSecond", pvExec, 16'h076c);
    wr(pvcos_pkg::REG_FILT, 16'h0000);
    settle();
    chk("lagOff", pvExec, 16'h2710);
  endtask : tFilter
  task automatic tBiasSlope();
    wr(pvcos_pkg::REG_SLOPE, 16'h05dc);
    wr(pvcos_pkg::REG_BIAS, 16'hfc18);
    pvSet <= 16'h1388;
    settle();
    chk("slopeBias", pvExec, 16'h1964);
    wr(pvcos_pkg::REG_BIAS, 16'h2711);
    rdChk("biasHigh", pvcos_pkg::REG_BIAS, 16'hfc18);
    wr(pvcos_pkg::REG_SLOPE, 16'h05dd);
    rdChk("slopeHigh", pvcos_pkg::REG_SLOPE, 16'h05dc);
    wr(pvcos_pkg::REG_BIAS, 16'h0000);
    wr(pvcos_pkg::REG_SLOPE, 16'h04b0);
  endtask : tBiasSlope
  task automatic tSqrt();
    wr(pvcos_pkg::REG_CTRL, 16'h0024);
    pvSet <= 16'h09c4;
    settle();
    chk("sqrtSlope", pvExec, 16'h1770);
    pvSet <= 16'h0064;
    settle();
    chk("lowCut", pvExec, 16'h0000);
    wr(pvcos_pkg::REG_CTRL, 16'h0020);
    settle();
    chk("sqrtOff", pvExec, 16'h0078);
    wr(pvcos_pkg::REG_SLOPE, 16'h03e8);
  endtask : tSqrt
  task automatic tLinear();
    logic [15:0] pin[3];
    logic [15:0] pdisp[3];
    int k;
    pin = '{16'h03e8, 16'h1388, 16'h2710};
    pdisp = '{16'h03e8, 16'h2328, 16'h2710};
    for (k = 0; k < 3; k++) begin
      wr(pvcos_pkg::REG_BP_IN + 6'(k), pin[k]);
      wr(pvcos_pkg::REG_BP_DISP + 6'(k), pdisp[k]);
    end
    wr(pvcos_pkg::REG_CTRL, 16'h0028);
    pvSet <= 16'h0bb8;
    settle();
    chk("linMid", pvExec, 16'h1388);
    pvSet <= 16'h01f4;
    settle();
    chk("linBelow", pvExec, 16'h0000);
    pvSet <= 16'h2904;
    settle();
    chk("linAbove", pvExec, 16'h2774);
    // Second point equal to the first leaves one valid point, so no mapping
    wr(pvcos_pkg::REG_BP_IN + 6'h01, 16'h03e8);
    pvSet <= 16'h0bb8;
    settle();
    chk("linBypass", pvExec, 16'h0bb8);
    wr(pvcos_pkg::REG_CTRL, 16'h0020);
  endtask : tLinear
  task automatic tRefuse();
    autoTuning <= 1'b1;
    wr(pvcos_pkg::REG_CTRL, 16'h0030);
    wr(6'h07, 16'h000a);
    chk("actTuning", {15'h0, actionDirectOne}, 16'h0000);
    rdChk("cycTuning", 6'h07, 16'h001e);
    @(posedge sys_clk);
    autoTuning <= 1'b0;
    rampActive <= 1'b1;
    wr(6'h07, 16'h000a);
    rdChk("cycRamp", 6'h07, 16'h001e);
    @(posedge sys_clk);
    rampActive <= 1'b0;
    wr(6'h07, 16'h0079);
    rdChk("cycHigh", 6'h07, 16'h001e);
    wr(6'h07, 16'h0001);
    rdChk("cycMin", 6'h07, 16'h0001);
    wr(pvcos_pkg::REG_CTRL, 16'h0030);
    repeat (2) @(posedge sys_clk);
    chk("actDirect", {15'h0, actionDirectOne}, 16'h0001);
    wr(pvcos_pkg::REG_CTRL, 16'h0020);
  endtask : tRefuse
  task automatic tFixed();
    wr(6'h05, 16'h0190);
    wr(6'h06, 16'h02bc);
    wr(6'h09, 16'h0258);
    wr(pvcos_pkg::REG_CTRL, 16'h0021);
    errSet <= 1'b1;
    settle();
    chk("stbyOne", {2'h0, outLevelOne}, 16'h0fa0);
    chk("stbyTwo", {2'h0, outLevelTwo}, 16'h1770);
    wr(pvcos_pkg::REG_CTRL, 16'h0020);
    settle();
    chk("errOne", {2'h0, outLevelOne}, 16'h1b58);
    wr(pvcos_pkg::REG_CTRL, 16'h0022);
    settle();
    chk("onOffHigh", {2'h0, outLevelOne}, 16'h2710);
    wr(6'h06, 16'h01f3);
    settle();
    chk("onOffLow", {2'h0, outLevelOne}, 16'h0000);
    @(posedge sys_clk);
    errSet <= 1'b0;
    ctrlDemandOne <= 10'h0fa;
    wr(pvcos_pkg::REG_CTRL, 16'h0020);
    settle();
    chk("demand", {2'h0, outLevelOne}, 16'h09c4);
  endtask : tFixed
  task automatic tRelay();
    logic [15:0] c0;
    @(posedge sys_clk);
    ctrlDemandOne <= 10'h12c;
    ctrlDemandTwo <= 10'h3e8;
    settle();
    chk("relayTwoOn", {15'h0, relayTwo}, 16'h0001);
    c0 = onCountOne;
    repeat (10 * PER) @(posedge sys_clk);
    #1;
    chk("relayOn", onCountOne - c0, 16'h0045);
  endtask : tRelay
  task automatic tRate();
    @(posedge sys_clk);
    ctrlDemandOne <= 10'h000;
    settle();
    wr(6'h08, 16'h000a);
    ctrlDemandOne <= 10'h3e8;
    waitMove(1'b1);
    chk("rateFirst", {2'h0, outLevelOne}, 16'h000a);
    waitMove(1'b1);
    chk("rateSecond", {2'h0, outLevelOne}, 16'h0014);
    wr(6'h08, 16'h03e9);
    rdChk("rateHigh", 6'h08, 16'h000a);
  endtask : tRate
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {regWrite, regRead, autoTuning, rampActive, errSet} = 5'h00;
    regAddr = 6'h00;
    regWdata = 16'h0000;
    pvSet = 16'h0000;
    ctrlDemandOne = 10'h000;
    ctrlDemandTwo = 10'h000;
    nFail = 0;
    checks = 0;
    cycles = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    tReset();
    tFilter();
    tBiasSlope();
    tSqrt();
    tLinear();
    tRefuse();
    tFixed();
    tRelay();
    tRate();
    wrapUp();
  end
endmodule : pvcos_conditioner_tb_top
`default_nettype wire
